// *** core/dlb_policer_pkg.sv ***
// constants and carrier types for the dual leaky bucket policer
package dlb_policer_pkg;

    // register byte offsets
    localparam logic [7:0]  CTRL_OFFSET       = 8'h00;
    localparam logic [7:0]  STICKY_OFFSET     = 8'h04;
    localparam logic [7:0]  DUAL_CFG_OFFSET   = 8'h08;
    localparam logic [7:0]  TRIPLE_CFG_OFFSET = 8'h10;
    localparam logic [7:0]  RATE_CFG_OFFSET   = 8'h14;
    localparam logic [7:0]  LAST_OFFSET       = 8'h2C;

    // policer and bucket counts, fill and length widths
    localparam int          DUAL_POLICERS     = 2;
    localparam int          DUAL_BUCKETS      = 4;
    localparam int          ALL_BUCKETS       = 7;
    localparam int          FILL_W            = 20;
    localparam int          LEN_W             = 14;

    // control register fields
    localparam int          DRAIN_EN_BIT      = 0;
    localparam int          CHARGE_EN_BIT     = 1;
    localparam int          SVC_MASK_LSB      = 2;
    localparam int          BDL_MASK_LSB      = 4;
    localparam int          TICK_LSB          = 16;
    localparam logic [31:0] CTRL_WRITE_MASK   = 32'hFFFF003F;
    localparam logic [31:0] CTRL_RESET        = 32'h0064003C;

    // traffic mask bits
    localparam int          MASK_CPU_BIT      = 0;
    localparam int          MASK_FRONT_BIT    = 1;

    // sticky flag positions
    localparam int          DROP_BIT          = 0;
    localparam int          OPEN_BIT          = 1;
    localparam int          CIR_BIT           = 2;
    localparam int          PIR_BIT           = 3;

    // bucket arithmetic
    localparam logic [10:0] BURST_UNIT_ZEROS  = 11'h000;
    localparam logic [1:0]  MAX_PRECEDENCE    = 2'h3;

    typedef enum logic [1:0] {
        SEL_SERVICE = 2'b00,
        SEL_BUNDLE  = 2'b01,
        SEL_FLOOD   = 2'b10,
        SEL_NONE    = 2'b11
    } policer_sel_type;

    typedef struct packed {
        logic [6:0] frameSizeAdjust;
        logic [1:0] excessPrecedenceIncrement;
        logic       couplingFlag;
        logic [1:0] greenThresholdLevel;
        logic [1:0] granularitySelect;
    } dual_cfg_type;

    typedef struct packed {
        logic [6:0]  burstThreshold;
        logic [10:0] bucketRate;
    } bucket_cfg_type;

    typedef struct packed {
        logic [6:0] frameSizeAdjust;
        logic [1:0] excessPrecedenceIncrement;
        logic [1:0] granularitySelect;
    } triple_cfg_type;

    typedef struct packed {
        logic            valid;
        policer_sel_type policer;
        logic [1:0]      floodClass;
        logic            toCpu;
        logic [1:0]      framePrecedence;
        logic [13:0]     length;
    } frame_in_type;

    typedef struct packed {
        logic       valid;
        logic       drop;
        logic       yellow;
        logic [1:0] framePrecedence;
    } frame_out_type;

endpackage : dlb_policer_pkg

// *** core/dual_leaky_bucket_policer.sv ***
// dual and triple leaky bucket frame policer with apb registers
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns

//Contract
//- each dual entry has a 2-bit granularity select for both buckets
//- precedence at or below green threshold is green, above is yellow
//- green threshold 3 makes every frame green, color-blind
//- committed overflow raises precedence by the increment field
//- a 7-bit gap value adjusts the counted frame size
//- each bucket rate is an 11-bit field, 2048 steps
//- burst threshold is 7 bits in 2 kilobyte units, 254 kilobytes max
//- traffic mask selects processor frames, front port frames or both
//- policing acts only with both drain and charge enables set
//- a base tick count sets the rate unit for the group
//- sticky flag on every dual policer drop until software clears
//- sticky flag when traffic passes without committed or peak policing
//- separate sticky flags for committed and peak rate exceeded
//- flood entry holds three buckets, 7-bit threshold, 11-bit rate each
//- flood entry has a shared 2-bit granularity select
//- flood entry has 2-bit precedence increment and 7-bit gap
//- gap is signed, minus 64 to plus 63 bytes, added to length
module dual_leaky_bucket_policer
    import dlb_policer_pkg::*;
(
    input  wire logic          sys_clk,
    input  wire logic          rstn,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [7:0]    paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire frame_in_type  frameIn,
    output frame_out_type      frameOut
);

    logic [31:0]      ctrl;
    logic [3:0]       sticky;
    logic [3:0]       stickySet;
    logic [3:0]       stickyClr;
    dual_cfg_type     dualCfg [DUAL_POLICERS];
    triple_cfg_type   tripleCfg;
    bucket_cfg_type   bucketCfg [ALL_BUCKETS];
    logic [FILL_W-1:0] fill [ALL_BUCKETS];
    logic [ALL_BUCKETS-1:0] inProfile;
    logic [ALL_BUCKETS-1:0] chargeVec;
    logic [FILL_W-1:0] chargeLen;
    logic [15:0]      tickCnt;
    logic             tick;
    logic             accessNow;
    logic [31:0]      readData;
    logic             regMapped;
    logic             policingOn;
    logic             dualIdx;
    dual_cfg_type     cfg;
    logic [1:0]       dualMask;
    logic             maskHit;
    logic             dualHit;
    logic             isGreen;
    logic [2:0]       b0Idx;
    logic [2:0]       b1Idx;
    logic [2:0]       floodIdx;
    frame_out_type    next_frameOut;

    // signed gap added to length, never below zero
    function automatic logic [FILL_W-1:0] adjustLen(
        input logic [LEN_W-1:0] len,
        input logic [6:0]       gap
    );
        logic signed [15:0] sum;
        sum = signed'({2'b00, len}) + signed'({{9{gap[6]}}, gap});
        return (sum < 0) ? '0 : {4'h0, sum[15:0]};
    endfunction : adjustLen

    function automatic logic [FILL_W-1:0] burstLimit(input bucket_cfg_type c);
        return {2'b00, c.burstThreshold, BURST_UNIT_ZEROS};
    endfunction : burstLimit

    // granularity scales the rate by four per step
    function automatic logic [FILL_W-1:0] drainAmount(
        input logic [10:0] rate,
        input logic [1:0]  gran
    );
        return {9'h000, rate} << {gran, 1'b0};
    endfunction : drainAmount

    // saturates at the highest precedence rather than wrapping
    function automatic logic [1:0] raisePrec(
        input logic [1:0] dp,
        input logic [1:0] inc
    );
        logic [2:0] sum;
        sum = {1'b0, dp} + {1'b0, inc};
        return sum[2] ? MAX_PRECEDENCE : sum[1:0];
    endfunction : raisePrec

    // apb slave: one wait state, answer registered
    assign accessNow = psel && penable && !pready;

    always_comb begin
        readData  = '0;
        regMapped = (paddr[1:0] == 2'b00) && (paddr <= LAST_OFFSET);
        case (paddr)
            CTRL_OFFSET:       readData = ctrl;
            STICKY_OFFSET:     readData = {28'h0, sticky};
            DUAL_CFG_OFFSET:   readData = {18'h0, dualCfg[0]};
            DUAL_CFG_OFFSET + 8'h04: readData = {18'h0, dualCfg[1]};
            TRIPLE_CFG_OFFSET: readData = {21'h0, tripleCfg};
            default: begin
                for (int i = 0; i < ALL_BUCKETS; i++) begin
                    if (paddr == RATE_CFG_OFFSET + 8'(4 * i)) begin
                        readData = {14'h0, bucketCfg[i]};
                    end
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else begin
            pready  <= accessNow;
            pslverr <= accessNow && !regMapped;
            if (accessNow && !pwrite) begin
                prdata <= regMapped ? readData : '0;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            ctrl      <= CTRL_RESET;
            dualCfg[0] <= '0;
            dualCfg[1] <= '0;
            tripleCfg <= '0;
            for (int i = 0; i < ALL_BUCKETS; i++) begin
                bucketCfg[i] <= '0;
            end
        end else if (accessNow && pwrite) begin
            case (paddr)
                CTRL_OFFSET:       ctrl <= pwdata & CTRL_WRITE_MASK;
                DUAL_CFG_OFFSET:   dualCfg[0] <= pwdata[13:0];
                DUAL_CFG_OFFSET + 8'h04: dualCfg[1] <= pwdata[13:0];
                TRIPLE_CFG_OFFSET: tripleCfg <= pwdata[10:0];
                default: begin
                    for (int i = 0; i < ALL_BUCKETS; i++) begin
                        if (paddr == RATE_CFG_OFFSET + 8'(4 * i)) begin
                            bucketCfg[i] <= pwdata[17:0];
                        end
                    end
                end
            endcase
        end
    end

    // write one to clear; a same-cycle event keeps its flag
    assign stickyClr = (accessNow && pwrite && paddr == STICKY_OFFSET)
                     ? pwdata[3:0] : 4'h0;

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            sticky <= '0;
        end else begin
            sticky <= (sticky & ~stickyClr) | stickySet;
        end
    end

    // base tick every count plus one cycles
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            tickCnt <= '0;
            tick    <= 1'b0;
        end else if (tickCnt >= ctrl[TICK_LSB +: 16]) begin
            tickCnt <= '0;
            tick    <= 1'b1;
        end else begin
            tickCnt <= tickCnt + 16'h0001;
            tick    <= 1'b0;
        end
    end

    // frame decision
    assign policingOn = ctrl[DRAIN_EN_BIT] && ctrl[CHARGE_EN_BIT];
    assign dualIdx    = (frameIn.policer == SEL_BUNDLE);
    assign cfg        = dualCfg[dualIdx];
    assign dualMask   = dualIdx ? ctrl[BDL_MASK_LSB +: 2]
                                : ctrl[SVC_MASK_LSB +: 2];
    assign maskHit    = frameIn.toCpu ? dualMask[MASK_CPU_BIT]
                                      : dualMask[MASK_FRONT_BIT];
    assign dualHit    = frameIn.valid && policingOn && maskHit
                     && (frameIn.policer == SEL_SERVICE
                      || frameIn.policer == SEL_BUNDLE);
    // threshold 3 covers every precedence, so color-blind falls out
    assign isGreen    = frameIn.framePrecedence
                     <= cfg.greenThresholdLevel;
    assign b0Idx      = {1'b0, dualIdx, 1'b0};
    assign b1Idx      = {1'b0, dualIdx, 1'b1};
    assign floodIdx   = 3'h4 + {1'b0, frameIn.floodClass};

    always_comb begin
        next_frameOut = '{valid: frameIn.valid, drop: 1'b0, yellow: 1'b0,
                          framePrecedence: frameIn.framePrecedence};
        chargeVec = '0;
        stickySet = '0;
        chargeLen = (frameIn.policer == SEL_FLOOD)
                  ? adjustLen(frameIn.length, tripleCfg.frameSizeAdjust)
                  : adjustLen(frameIn.length, cfg.frameSizeAdjust);
        if (frameIn.valid && policingOn) begin
            unique case (frameIn.policer)
                SEL_SERVICE, SEL_BUNDLE: begin
                    if (!maskHit) begin
                        next_frameOut.valid = frameIn.valid;
                    end else if (isGreen && inProfile[b0Idx]) begin
                        chargeVec[b0Idx] = 1'b1;
                        // coupled bucket 1 tracks the total, so green
                        // traffic is charged there too
                        chargeVec[b1Idx] = cfg.couplingFlag;
                        stickySet[OPEN_BIT] = 1'b1;
                    end else begin
                        stickySet[CIR_BIT] = isGreen;
                        if (inProfile[b1Idx]) begin
                            chargeVec[b1Idx] = 1'b1;
                            next_frameOut.yellow = 1'b1;
                            if (isGreen) begin
                                next_frameOut.framePrecedence = raisePrec(
                                    frameIn.framePrecedence,
                                    cfg.excessPrecedenceIncrement);
                            end
                        end else begin
                            next_frameOut.drop = 1'b1;
                            stickySet[PIR_BIT]  = 1'b1;
                            stickySet[DROP_BIT] = 1'b1;
                        end
                    end
                end
                SEL_FLOOD: begin
                    // class 3 has no bucket and passes untouched
                    if (frameIn.floodClass == 2'h3) begin
                        next_frameOut.valid = frameIn.valid;
                    end else if (inProfile[floodIdx]) begin
                        chargeVec[floodIdx] = 1'b1;
                    end else if (tripleCfg.excessPrecedenceIncrement
                                 != 2'h0) begin
                        next_frameOut.yellow = 1'b1;
                        next_frameOut.framePrecedence = raisePrec(
                            frameIn.framePrecedence,
                            tripleCfg.excessPrecedenceIncrement);
                    end else begin
                        next_frameOut.drop = 1'b1;
                    end
                end
                SEL_NONE: begin
                    next_frameOut.valid = frameIn.valid;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            frameOut <= '0;
        end else begin
            frameOut <= next_frameOut;
        end
    end

    // buckets 0-3 belong to the two dual policers, 4-6 to flood classes
    for (genvar g = 0; g < ALL_BUCKETS; g++) begin : bucketGen
        logic [1:0]        gran;
        logic [FILL_W-1:0] drain;
        logic [FILL_W-1:0] drained;
        if (g < DUAL_BUCKETS) begin : dualGran
            assign gran = dualCfg[g / 2].granularitySelect;
        end else begin : floodGran
            assign gran = tripleCfg.granularitySelect;
        end
        assign drain = drainAmount(bucketCfg[g].bucketRate, gran);
        assign drained = (tick && ctrl[DRAIN_EN_BIT])
                       ? ((fill[g] > drain) ? fill[g] - drain : '0)
                       : fill[g];
        assign inProfile[g] = fill[g] <= burstLimit(bucketCfg[g]);
        always_ff @(posedge sys_clk) begin
            if (!rstn) begin
                fill[g] <= '0;
            end else begin
                fill[g] <= drained + (chargeVec[g] ? chargeLen : '0);
            end
        end
    end

    color_blind_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        dualHit && cfg.greenThresholdLevel == 2'h3 && inProfile[b0Idx]
        |=> frameOut.valid && !frameOut.yellow && !frameOut.drop)
        else $error("color-blind frame not treated as green");

    yellow_class_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        dualHit && frameIn.framePrecedence > cfg.greenThresholdLevel
        |=> frameOut.yellow || frameOut.drop)
        else $error("yellow frame passed as green");

    dp_raise_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        dualHit && isGreen && !inProfile[b0Idx] && inProfile[b1Idx]
        |=> frameOut.framePrecedence == raisePrec(
            $past(frameIn.framePrecedence),
            $past(cfg.excessPrecedenceIncrement)))
        else $error("excess precedence not raised by increment");

    policing_gate_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        frameIn.valid && !policingOn
        |=> frameOut.valid && !frameOut.drop && !frameOut.yellow)
        else $error("policing acted while globally disabled");

    drop_sticky_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        dualHit && !inProfile[b1Idx] && !(isGreen && inProfile[b0Idx])
        |=> frameOut.drop && sticky[DROP_BIT] && sticky[PIR_BIT])
        else $error("excess failure not dropped and flagged");

    sticky_hold_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        sticky[DROP_BIT] && !stickyClr[DROP_BIT] |=> sticky[DROP_BIT])
        else $error("drop flag lost without a clear");

    open_flag_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        dualHit && isGreen && inProfile[b0Idx]
        |=> sticky[OPEN_BIT] && !frameOut.drop)
        else $error("in-profile pass not flagged");

    cir_flag_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        dualHit && isGreen && !inProfile[b0Idx] |=> sticky[CIR_BIT])
        else $error("committed overflow not flagged");

    mask_skip_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        frameIn.valid && policingOn && !maskHit
        && frameIn.policer inside {SEL_SERVICE, SEL_BUNDLE}
        |=> !frameOut.drop && !frameOut.yellow)
        else $error("masked traffic type was policed");

    tick_space_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        tick && ctrl[TICK_LSB +: 16] != 16'h0000
        && $stable(ctrl[TICK_LSB +: 16]) |=> !tick)
        else $error("base ticks closer than the tick count");

endmodule : dual_leaky_bucket_policer

// *** sim/frame_source.sv ***
// partner model: classification pipeline handing frame metadata
`timescale 1ns/1ns
module frame_source
    import dlb_policer_pkg::*;
(
    input  wire logic    sys_clk,
    output frame_in_type frameIn
);
    initial frameIn = '0;

    // one beat per call, no back-pressure on this side
    task send(input frame_in_type f);
        @(posedge sys_clk);
        frameIn <= f;
    endtask : send

    // released fields are inverted so stale metadata never looks fresh
    task idle();
        @(posedge sys_clk);
        frameIn <= {1'b0, ~frameIn[$bits(frame_in_type)-2:0]};
    endtask : idle
endmodule : frame_source

// *** sim/tb.sv ***
// self-checking bench for the dual leaky bucket policer
`timescale 1ns/1ns
module tb
    import dlb_policer_pkg::*;
;
    typedef struct packed {
        frame_out_type v;
        logic          full;
    } note_type;

    logic          sys_clk = 1'b0;
    logic          rstn    = 1'b0;
    logic          psel    = 1'b0;
    logic          penable = 1'b0;
    logic          pwrite  = 1'b0;
    logic [7:0]    paddr   = 8'h00;
    logic [31:0]   pwdata  = 32'h00000000;
    wire  [31:0]   prdata;
    wire           pready;
    wire           pslverr;
    wire frame_in_type  frameIn;
    wire frame_out_type frameOut;
    note_type      notes[$];
    note_type      n;
    int            err_total  = 0;
    int            num_checks = 0;
    int            i;
    logic [1:0]    rp;
    logic [1:0]    fc = 2'h0;

    always #25 sys_clk = ~sys_clk;

    dual_leaky_bucket_policer dual_leaky_bucket_policer_inst (
        .sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .frameIn(frameIn),
        .frameOut(frameOut));

    frame_source frame_source_inst (.sys_clk(sys_clk), .frameIn(frameIn));

    task chk(input string what, input logic [31:0] exp,
             input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            $display("wrong value %s exp %h got %h", what, exp, got);
            err_total++;
        end
    endtask : chk

    // wait for pready is bounded; the bench assumes no fixed latency
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
             input logic [31:0] exp, input logic e);
        int k;
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge sys_clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        psel    <= 1'b0;
        penable <= 1'b0;
        chk("pready", 32'h1, {31'h0, pready});
        chk("pslverr", {31'h0, e}, {31'h0, pslverr});
        if (!w) chk("prdata", exp, prdata);
    endtask : apb

    task frm(input policer_sel_type s, input logic cpu, input logic [1:0] dp,
             input logic [13:0] len, input logic [1:0] odp, input logic y,
             input logic d);
        notes.push_back({1'b1, d, y, odp, ~d});
        frame_source_inst.send({1'b1, s, fc, cpu, dp, len});
    endtask : frm

    task done(input string t);
        $display("test %s done", t);
    endtask : done

    task wrap_up();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : wrap_up

    // drop results leave yellow and precedence unspecified
    always @(posedge sys_clk) begin
        if (frameOut.valid === 1'b1) begin
            if (notes.size() == 0) begin
                chk("spare frame", 32'h0, 32'h1);
            end else begin
                n = notes.pop_front();
                if (n.full)
                    chk("frame", {27'h0, n.v}, {27'h0, frameOut});
                else
                    chk("drop", {30'h0, n.v.valid, n.v.drop},
                        {30'h0, frameOut.valid, frameOut.drop});
            end
        end
    end

    initial begin
        repeat (5000) @(posedge sys_clk);
        err_total++;
        $display("watchdog expired");
        wrap_up();
    end

    initial begin
        void'($urandom(90734));
        repeat (8) @(posedge sys_clk);
        rstn <= 1'b1;
        apb(0, CTRL_OFFSET, 0, CTRL_RESET, 0);
        apb(0, STICKY_OFFSET, 0, 32'h0, 0);
        apb(0, DUAL_CFG_OFFSET, 0, 32'h0, 0);
        apb(0, 8'h30, 0, 32'h0, 1);
        apb(1, 8'h0C, 32'hFFFFFFFF, 0, 0);
        apb(0, 8'h0C, 0, 32'h3FFF, 0);
        apb(1, TRIPLE_CFG_OFFSET, 32'hFFFFFFFF, 0, 0);
        apb(0, TRIPLE_CFG_OFFSET, 0, 32'h7FF, 0);
        apb(1, LAST_OFFSET, 32'hFFFFFFFF, 0, 0);
        apb(0, LAST_OFFSET, 0, 32'h3FFFF, 0);
        done("registers");
        for (i = 0; i < 6; i++) begin
            rp = 2'($urandom_range(3));
            fc = 2'($urandom_range(3));
            frm(policer_sel_type'($urandom_range(3)), 1'($urandom_range(1)),
                rp, 14'($urandom_range(16383)), rp, 1'b0, 1'b0);
        end
        fc = 2'h0;
        frame_source_inst.idle();
        done("disabled");
        // slow tick so nothing drains during the service walk
        apb(1, CTRL_OFFSET, 32'hFFFF003F, 0, 0);
        apb(1, DUAL_CFG_OFFSET, 32'h24, 0, 0);
        apb(1, RATE_CFG_OFFSET, 32'h0, 0, 0);
        apb(1, 8'h18, 32'h800, 0, 0);
        frm(SEL_SERVICE, 0, 2'h0, 1000, 2'h0, 0, 0);
        frm(SEL_SERVICE, 0, 2'h1, 1000, 2'h2, 1, 0);
        frm(SEL_SERVICE, 0, 2'h0, 1000, 2'h1, 1, 0);
        frm(SEL_SERVICE, 0, 2'h2, 1000, 2'h2, 1, 0);
        frm(SEL_SERVICE, 0, 2'h0, 1000, 2'h0, 0, 1);
        frame_source_inst.idle();
        apb(0, STICKY_OFFSET, 0, 32'hF, 0);
        apb(1, STICKY_OFFSET, 32'h1, 0, 0);
        apb(0, STICKY_OFFSET, 0, 32'hE, 0);
        done("service");
        apb(1, CTRL_OFFSET, 32'hFFFF003B, 0, 0);
        frm(SEL_SERVICE, 1, 2'h0, 1000, 2'h0, 0, 0);
        frm(SEL_SERVICE, 0, 2'h0, 1000, 2'h0, 0, 1);
        frame_source_inst.idle();
        done("mask");
        apb(1, CTRL_OFFSET, 32'hFFFF003F, 0, 0);
        apb(1, 8'h0C, 32'h4C, 0, 0);
        apb(1, 8'h1C, 32'h0, 0, 0);
        apb(1, 8'h20, 32'h5000, 0, 0);
        frm(SEL_BUNDLE, 0, 2'h3, 500, 2'h3, 0, 0);
        frm(SEL_BUNDLE, 0, 2'h2, 500, 2'h3, 1, 0);
        frame_source_inst.idle();
        done("bundle");
        // zero rate keeps the fill still while the gap is probed
        apb(1, CTRL_OFFSET, 32'h0003003F, 0, 0);
        apb(1, TRIPLE_CFG_OFFSET, 32'h400, 0, 0);
        apb(1, 8'h24, 32'h0, 0, 0);
        frm(SEL_FLOOD, 0, 2'h0, 64, 2'h0, 0, 0);
        frm(SEL_FLOOD, 0, 2'h0, 65, 2'h0, 0, 0);
        frm(SEL_FLOOD, 0, 2'h0, 64, 2'h0, 0, 1);
        frame_source_inst.idle();
        apb(1, 8'h24, 32'h1, 0, 0);
        repeat (10) @(posedge sys_clk);
        frm(SEL_FLOOD, 0, 2'h0, 64, 2'h0, 0, 0);
        frame_source_inst.idle();
        // class 1 has a zero limit, so its second frame overflows
        apb(1, TRIPLE_CFG_OFFSET, 32'h408, 0, 0);
        fc = 2'h1;
        frm(SEL_FLOOD, 0, 2'h0, 65, 2'h0, 0, 0);
        frm(SEL_FLOOD, 0, 2'h1, 65, 2'h3, 1, 0);
        fc = 2'h3;
        frm(SEL_FLOOD, 0, 2'h1, 65, 2'h1, 0, 0);
        fc = 2'h0;
        frame_source_inst.idle();
        done("flood");
        // uncoupled the last frame would go yellow; coupled bucket 1 is full
        apb(1, CTRL_OFFSET, 32'hFFFF003F, 0, 0);
        apb(1, DUAL_CFG_OFFSET, 32'h1C, 0, 0);
        apb(1, RATE_CFG_OFFSET, 32'h800, 0, 0);
        apb(1, 8'h18, 32'h1000, 0, 0);
        frm(SEL_SERVICE, 0, 2'h0, 1000, 2'h0, 0, 0);
        frm(SEL_SERVICE, 0, 2'h0, 100, 2'h0, 0, 0);
        frm(SEL_SERVICE, 0, 2'h0, 100, 2'h0, 0, 1);
        frame_source_inst.idle();
        // about five ticks bring the fill in profile only at granularity 2 or 3
        apb(1, DUAL_CFG_OFFSET, 32'h1E, 0, 0);
        apb(1, RATE_CFG_OFFSET, 32'h801, 0, 0);
        apb(1, CTRL_OFFSET, 32'h0000003F, 0, 0);
        repeat (4) @(posedge sys_clk);
        frm(SEL_SERVICE, 0, 2'h0, 100, 2'h0, 0, 0);
        frame_source_inst.idle();
        done("coupled");
        @(posedge sys_clk);
        rstn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rstn <= 1'b1;
        apb(0, CTRL_OFFSET, 0, CTRL_RESET, 0);
        apb(0, STICKY_OFFSET, 0, 32'h0, 0);
        done("reset");
        repeat (4) @(posedge sys_clk);
        chk("pending notes", 32'h0, 32'(notes.size()));
        wrap_up();
    end
endmodule : tb
